// ===== fcsm_ctrl.v
// host controller that issues flash command sequences over the parallel pins
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_regs.vh"

// How it works
// - autoselect is left only by a reset write, back to read-array.
// - failure flag high during program or erase: host writes a reset.
// - autoselect: two unlocks plus command, then reads at any address repeatedly.
// - byte program: two unlocks, setup command, then address and data.
// - commands during programming are ignored; reissue after completion.
// - bypass entry: two unlocks then data 20h.
// - bypass program: A0h then address and data, repeated per byte.
// - bypass exit: 90h then 00h, address ignored, back to read-array.
// - chip erase: two unlocks, setup, two unlocks, erase command.
module fcsm_ctrl (
   // clock and reset
   input wire clk_in,
   input wire resetn_in,
   // apb slave
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [7:0] paddr_in,
   input wire [31:0] pwdata_in,
   output wire [31:0] prdata_out,
   output wire pready_out,
   output wire pslverr_out,
   // flash pins
   output wire [16:0] flash_addr_out,
   output wire flash_ce_n_out,
   output wire flash_we_n_out,
   output wire flash_oe_n_out,
   input wire [7:0] byte_data_lines_in,
   output wire [7:0] byte_data_lines_out,
   output wire byte_data_lines_oe_n_out
);

   // ---------------------------------------------------------------------------
   // timing counts
   // ---------------------------------------------------------------------------
   localparam [31:0] WP_CYC = (`FCSM_T_WP_NS * `FCSM_CLK_MHZ + 999) / 1000;
   localparam [31:0] WPH_CYC = (`FCSM_T_WPH_NS * `FCSM_CLK_MHZ + 999) / 1000;
   localparam [31:0] RD_CYC = (`FCSM_T_ACC_NS * `FCSM_CLK_MHZ + 999) / 1000
      + `FCSM_SYNC_STAGES;

   // bus cycle states
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_WSET = 3'h1;
   localparam [2:0] S_WLOW = 3'h2;
   localparam [2:0] S_WHIGH = 3'h3;
   localparam [2:0] S_RSET = 3'h4;
   localparam [2:0] S_RLOW = 3'h5;

   // ---------------------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------------------
   reg [2:0] state_q;
   reg [2:0] op_q;
   reg [2:0] step_q;
   reg [3:0] cnt_q;
   reg busy_q;
   reg done_q;
   reg fail_q;
   reg refused_q;
   reg bypass_q;
   reg autosel_q;
   reg polling_q;
   reg have_prev_q;
   reg fail_pend_q;
   reg [7:0] prev_q;
   reg [16:0] addr_reg_q;
   reg [7:0] wdata_reg_q;
   reg [7:0] rdata_q;
   reg [31:0] prdata_q;
   reg [16:0] flash_addr_q;
   reg [7:0] dout_q;
   reg ce_n_q;
   reg we_n_q;
   reg oe_n_q;
   reg drive_q;

   wire [7:0] dq_sync;
   reg [2:0] seq_last;
   reg [16:0] seq_addr;
   reg [7:0] seq_data;
   reg op_ok;
   reg mapped;
   reg [31:0] rd_mux;

   wire wr_access = psel_in & penable_in & pwrite_in;
   wire setup_phase = psel_in & ~penable_in;
   wire [2:0] new_op = pwdata_in[`FCSM_CTRL_OP_MSB:`FCSM_CTRL_OP_LSB];
   wire ctrl_wr = wr_access & (paddr_in == `FCSM_REG_CTRL);
   wire last_step = (step_q == seq_last);
   wire polls = (op_q == `FCSM_OP_PROGRAM) | (op_q == `FCSM_OP_BYP_PROGRAM) |
      (op_q == `FCSM_OP_CHIP_ERASE);

   // ---------------------------------------------------------------------------
   // data line synchroniser
   // ---------------------------------------------------------------------------
   fcsm_sync #(
      .W(8)
   ) u_dq_sync (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .d_in(byte_data_lines_in),
      .q_out(dq_sync)
   );

   // ---------------------------------------------------------------------------
   // command sequence tables
   // ---------------------------------------------------------------------------
   // bus cycles of each operation, address and data per step
   always @* begin
      seq_last = 3'h0;
      seq_addr = `FCSM_DONT_CARE_ADDR;
      seq_data = `FCSM_CMD_RESET;
      case (op_q)
         `FCSM_OP_RESET: begin
            seq_last = 3'h0;
         end
         `FCSM_OP_AUTOSEL, `FCSM_OP_PROGRAM, `FCSM_OP_BYP_ENTER: begin
            seq_last = (op_q == `FCSM_OP_PROGRAM) ? 3'h3 : 3'h2;
            case (step_q)
               3'h0: begin
                  seq_addr = `FCSM_UNLOCK_ADDR1;
                  seq_data = `FCSM_UNLOCK_DATA1;
               end
               3'h1: begin
                  seq_addr = `FCSM_UNLOCK_ADDR2;
                  seq_data = `FCSM_UNLOCK_DATA2;
               end
               3'h2: begin
                  seq_addr = `FCSM_UNLOCK_ADDR1;
                  if (op_q == `FCSM_OP_AUTOSEL) begin
                     seq_data = `FCSM_CMD_AUTOSEL;
                  end else if (op_q == `FCSM_OP_PROGRAM) begin
                     seq_data = `FCSM_CMD_PROGRAM;
                  end else begin
                     seq_data = `FCSM_CMD_BYPASS;
                  end
               end
               default: begin
                  seq_addr = addr_reg_q;
                  seq_data = wdata_reg_q;
               end
            endcase
         end
         `FCSM_OP_BYP_PROGRAM: begin
            seq_last = 3'h1;
            if (step_q == 3'h0) begin
               seq_data = `FCSM_CMD_PROGRAM;
            end else begin
               seq_addr = addr_reg_q;
               seq_data = wdata_reg_q;
            end
         end
         `FCSM_OP_BYP_EXIT: begin
            seq_last = 3'h1;
            seq_data = (step_q == 3'h0) ? `FCSM_CMD_BYP_EXIT1 : `FCSM_CMD_BYP_EXIT2;
         end
         `FCSM_OP_CHIP_ERASE: begin
            seq_last = 3'h5;
            case (step_q)
               3'h0, 3'h3: begin
                  seq_addr = `FCSM_UNLOCK_ADDR1;
                  seq_data = `FCSM_UNLOCK_DATA1;
               end
               3'h1, 3'h4: begin
                  seq_addr = `FCSM_UNLOCK_ADDR2;
                  seq_data = `FCSM_UNLOCK_DATA2;
               end
               3'h2: begin
                  seq_addr = `FCSM_UNLOCK_ADDR1;
                  seq_data = `FCSM_CMD_ERASE_SETUP;
               end
               default: begin
                  seq_addr = `FCSM_UNLOCK_ADDR1;
                  seq_data = `FCSM_CMD_CHIP_ERASE;
               end
            endcase
         end
         default: begin
            seq_last = 3'h0;
         end
      endcase
   end

   // which operations the device will take in its present mode
   always @* begin
      if (bypass_q) begin
         op_ok = (new_op == `FCSM_OP_BYP_PROGRAM) | (new_op == `FCSM_OP_BYP_EXIT) |
            (new_op == `FCSM_OP_READ);
      end else if (autosel_q) begin
         op_ok = (new_op == `FCSM_OP_RESET) | (new_op == `FCSM_OP_READ);
      end else begin
         op_ok = (new_op != `FCSM_OP_BYP_PROGRAM) & (new_op != `FCSM_OP_BYP_EXIT);
      end
   end

   // ---------------------------------------------------------------------------
   // apb register file
   // ---------------------------------------------------------------------------
   // read mux, sampled in the setup cycle so read data comes from a flop
   always @* begin
      mapped = 1'b1;
      rd_mux = 32'h00000000;
      case (paddr_in)
         `FCSM_REG_CTRL: rd_mux = {29'h00000000, op_q};
         `FCSM_REG_STATUS: begin
            rd_mux[`FCSM_ST_BUSY] = busy_q;
            rd_mux[`FCSM_ST_DONE] = done_q;
            rd_mux[`FCSM_ST_FAIL] = fail_q;
            rd_mux[`FCSM_ST_REFUSED] = refused_q;
            rd_mux[`FCSM_ST_BYPASS] = bypass_q;
            rd_mux[`FCSM_ST_AUTOSEL] = autosel_q;
         end
         `FCSM_REG_ADDR: rd_mux = {15'h0000, addr_reg_q};
         `FCSM_REG_WDATA: rd_mux = {24'h000000, wdata_reg_q};
         `FCSM_REG_RDATA: rd_mux = {24'h000000, rdata_q};
         default: mapped = 1'b0;
      endcase
   end

   // zero wait states: the access phase always completes
   assign pready_out = psel_in & penable_in;
   assign pslverr_out = psel_in & penable_in & ~mapped;
   assign prdata_out = prdata_q;

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         prdata_q <= 32'h00000000;
         addr_reg_q <= `FCSM_ADDR_RESET;
         wdata_reg_q <= `FCSM_WDATA_RESET;
      end else begin
         if (setup_phase) begin
            prdata_q <= rd_mux;
         end
         // operands are frozen while a sequence runs, so table lookups stay stable
         if (wr_access & ~busy_q & (paddr_in == `FCSM_REG_ADDR)) begin
            addr_reg_q <= pwdata_in[16:0];
         end
         if (wr_access & ~busy_q & (paddr_in == `FCSM_REG_WDATA)) begin
            wdata_reg_q <= pwdata_in[7:0];
         end
      end
   end

   // ---------------------------------------------------------------------------
   // bus cycle engine
   // ---------------------------------------------------------------------------
   // strobes idle high from reset so no write is seen at power-up
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= S_IDLE;
         op_q <= `FCSM_OP_RESET;
         step_q <= 3'h0;
         cnt_q <= 4'h0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         refused_q <= 1'b0;
         bypass_q <= 1'b0;
         autosel_q <= 1'b0;
         polling_q <= 1'b0;
         have_prev_q <= 1'b0;
         fail_pend_q <= 1'b0;
         prev_q <= 8'h00;
         rdata_q <= 8'h00;
         flash_addr_q <= 17'h00000;
         dout_q <= 8'h00;
         ce_n_q <= 1'b1;
         we_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         drive_q <= 1'b0;
      end else begin
         // a start while busy is dropped but flagged
         if (ctrl_wr & busy_q) begin
            refused_q <= 1'b1;
         end
         case (state_q)
            S_IDLE: begin
               if (ctrl_wr) begin
                  if (busy_q | ~op_ok) begin
                     refused_q <= 1'b1;
                  end else begin
                     op_q <= new_op;
                     step_q <= 3'h0;
                     busy_q <= 1'b1;
                     done_q <= 1'b0;
                     fail_q <= 1'b0;
                     refused_q <= 1'b0;
                     polling_q <= 1'b0;
                     state_q <= (new_op == `FCSM_OP_READ) ? S_RSET : S_WSET;
                  end
               end
            end
            S_WSET: begin
               // address settles before the strobes fall
               flash_addr_q <= seq_addr;
               dout_q <= seq_data;
               drive_q <= 1'b1;
               state_q <= S_WLOW;
               cnt_q <= WP_CYC[3:0];
            end
            S_WLOW: begin
               ce_n_q <= 1'b0;
               we_n_q <= 1'b0;
               if (cnt_q == 4'h1) begin
                  state_q <= S_WHIGH;
                  cnt_q <= WPH_CYC[3:0];
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            S_WHIGH: begin
               // both strobes rise while data is still driven
               ce_n_q <= 1'b1;
               we_n_q <= 1'b1;
               if (cnt_q == 4'h1) begin
                  drive_q <= 1'b0;
                  if (!last_step) begin
                     step_q <= step_q + 3'h1;
                     state_q <= S_WSET;
                  end else if (polls) begin
                     // wait for completion before releasing the host
                     polling_q <= 1'b1;
                     have_prev_q <= 1'b0;
                     fail_pend_q <= 1'b0;
                     state_q <= S_RSET;
                  end else begin
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                     state_q <= S_IDLE;
                     if (op_q == `FCSM_OP_RESET) begin
                        bypass_q <= 1'b0;
                        autosel_q <= 1'b0;
                     end
                     if (op_q == `FCSM_OP_AUTOSEL) begin
                        autosel_q <= 1'b1;
                     end
                     if (op_q == `FCSM_OP_BYP_ENTER) begin
                        bypass_q <= 1'b1;
                     end
                     if (op_q == `FCSM_OP_BYP_EXIT) begin
                        bypass_q <= 1'b0;
                     end
                  end
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            S_RSET: begin
               // autoselect reads use the user address as is
               flash_addr_q <= polling_q ? flash_addr_q : addr_reg_q;
               state_q <= S_RLOW;
               // strobes rise in the count's last cycle: one more keeps access plus sync time
               cnt_q <= RD_CYC[3:0] + 4'h1;
            end
            S_RLOW: begin
               ce_n_q <= 1'b0;
               oe_n_q <= 1'b0;
               if (cnt_q == 4'h1) begin
                  ce_n_q <= 1'b1;
                  oe_n_q <= 1'b1;
                  if (!polling_q) begin
                     rdata_q <= dq_sync;
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                     state_q <= S_IDLE;
                  end else if (!have_prev_q) begin
                     prev_q <= dq_sync;
                     have_prev_q <= 1'b1;
                     state_q <= S_RSET;
                  end else if (prev_q[`FCSM_DQ_TOGGLE] == dq_sync[`FCSM_DQ_TOGGLE]) begin
                     // toggle bit stopped: back in read-array
                     rdata_q <= dq_sync;
                     polling_q <= 1'b0;
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                     state_q <= S_IDLE;
                  end else if (fail_pend_q) begin
                     // still toggling after the fail flag: force a reset
                     fail_q <= 1'b1;
                     polling_q <= 1'b0;
                     bypass_q <= 1'b0;
                     op_q <= `FCSM_OP_RESET;
                     step_q <= 3'h0;
                     state_q <= S_WSET;
                  end else begin
                     // one more read, compared with this one, decides a flagged failure
                     fail_pend_q <= dq_sync[`FCSM_DQ_FAIL];
                     prev_q <= dq_sync;
                     state_q <= S_RSET;
                  end
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------------------
   // pin outputs
   // ---------------------------------------------------------------------------
   assign flash_addr_out = flash_addr_q;
   assign flash_ce_n_out = ce_n_q;
   assign flash_we_n_out = we_n_q;
   assign flash_oe_n_out = oe_n_q;
   assign byte_data_lines_out = dout_q;
   assign byte_data_lines_oe_n_out = ~drive_q;

endmodule
`default_nettype wire

// ===== fcsm_ctrl_sva.sv
// checker for the flash pin timing of the command controller
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// pin relations
// ----------------------------------------
module fcsm_ctrl_chk (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // apb
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pready_out,
   // flash pins
   input wire logic [16:0] flash_addr_out,
   input wire logic flash_ce_n_out,
   input wire logic flash_we_n_out,
   input wire logic flash_oe_n_out,
   input wire logic [7:0] byte_data_lines_out,
   input wire logic byte_data_lines_oe_n_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   property p_idle; $rose(resetn_in) |-> flash_ce_n_out && flash_we_n_out && flash_oe_n_out; endproperty
   a_idle: assert property (p_idle) else $error("strobes not idle after reset");
   // a write strobe with output gate low would not be taken as a write
   property p_inh; !flash_we_n_out |-> flash_oe_n_out && !flash_ce_n_out; endproperty
   a_inh: assert property (p_inh) else $error("write strobe without select or with gate");
   property p_wp; $fell(flash_we_n_out) |-> !flash_we_n_out[*2] ##1 flash_we_n_out[*2]; endproperty
   a_wp: assert property (p_wp) else $error("write pulse shape wrong");
   property p_adr; !flash_we_n_out |-> $stable(flash_addr_out); endproperty
   a_adr: assert property (p_adr) else $error("address moved in write pulse");
   property p_ahold; $rose(flash_we_n_out) |-> $stable(flash_addr_out)[*2]; endproperty
   a_ahold: assert property (p_ahold) else $error("address moved after write pulse");
   property p_dat; !flash_we_n_out |-> $stable(byte_data_lines_out) && !byte_data_lines_oe_n_out;
   endproperty
   a_dat: assert property (p_dat) else $error("data not driven steady in write");
   property p_rdd; !flash_oe_n_out |-> byte_data_lines_oe_n_out && flash_we_n_out; endproperty
   a_rdd: assert property (p_rdd) else $error("contention during read");
   property p_rdl; $fell(flash_oe_n_out) |-> !flash_oe_n_out[*6] ##1 flash_oe_n_out; endproperty
   a_rdl: assert property (p_rdl) else $error("read strobe length wrong");
   property p_rdy; psel_in && penable_in |-> pready_out; endproperty
   a_rdy: assert property (p_rdy) else $error("access phase not answered");
endmodule
bind fcsm_ctrl fcsm_ctrl_chk u_chk (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
   .penable_in(penable_in), .pready_out(pready_out), .flash_addr_out(flash_addr_out),
   .flash_ce_n_out(flash_ce_n_out), .flash_we_n_out(flash_we_n_out),
   .flash_oe_n_out(flash_oe_n_out), .byte_data_lines_out(byte_data_lines_out),
   .byte_data_lines_oe_n_out(byte_data_lines_oe_n_out));
`default_nettype wire

// ===== fcsm_flash_mdl.sv
// behavioural model of the byte-wide flash device
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// device model
// ----------------------------------------
module fcsm_flash_mdl #(
   parameter logic [7:0] MAKER = 8'hC5, // arbitrary
   parameter logic [7:0] DEV = 8'h3A // arbitrary
) (
   // pins
   input wire logic [16:0] addr_in,
   input wire logic ce_n_in,
   input wire logic we_n_in,
   input wire logic oe_n_in,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out
);
   logic [7:0] mem [int];
   logic [16:0] la;
   logic [7:0] pd;
   logic [3:0] n = 0;
   logic [1:0] md = 0; // read-array at power-up
   logic tg = 0;
   int busy = 0;
   wire wr_n = ce_n_in | we_n_in;
   wire rd_n = ce_n_in | oe_n_in;
   initial data_out = 8'h00;
   // stored zeros stay zero
   task automatic prog;
      mem[la] = (mem.exists(la) ? mem[la] : 8'hFF) & data_in;
      pd = data_in;
      busy = 4;
   endtask
   // address on the later falling edge
   always @(negedge wr_n) la = addr_in;
   // data on the first rising edge, only with gate high
   always @(posedge wr_n) if (oe_n_in) begin
      if (busy > 0) ;
      else if (md == 2'd2) begin
         if (n == 0) n = data_in == 8'hA0 ? 4'h7 : data_in == 8'h90 ? 4'h8 : 4'h0;
         else if (n == 7) begin prog(); n = 0; end
         else begin if (data_in == 8'h00) md = 0; n = 0; end
      end
      else if (data_in == 8'hF0) begin n = 0; md = 0; end
      else if (md == 2'd0) begin
         if (n == 3) begin prog(); n = 0; end
         else if ((n == 0 || n == 4) && la == 17'h555 && data_in == 8'hAA) n = n + 1;
         else if ((n == 1 || n == 5) && la == 17'h2AA && data_in == 8'h55) n = n + 1;
         else if (n == 2 && la == 17'h555 && data_in == 8'h90) begin md = 1; n = 0; end
         else if (n == 2 && la == 17'h555 && data_in == 8'hA0) n = 3;
         else if (n == 2 && la == 17'h555 && data_in == 8'h20) begin md = 2; n = 0; end
         else if (n == 2 && la == 17'h555 && data_in == 8'h80) n = 4;
         else if (n == 6 && la == 17'h555 && data_in == 8'h10) begin
            mem.delete();
            pd = 8'hFF;
            busy = 6;
            n = 0;
         end
         else n = 0;
      end
   end
   // reads give status while busy, ids in autoselect, else array
   always @(negedge rd_n) if (we_n_in) begin
      if (busy > 0) begin
         tg = ~tg;
         busy = busy - 1;
         data_out = {~pd[7], tg, 6'h00};
      end
      else if (md == 2'd1) data_out = addr_in[7:0] == 8'h00 ? MAKER : addr_in[7:1] == 7'h00 ? DEV : 8'h00;
      else data_out = mem.exists(addr_in) ? mem[addr_in] : 8'hFF;
   end
   // released lines must not keep the last value
   always @(posedge rd_n) data_out = ~data_out;
endmodule
`default_nettype wire

// ===== fcsm_regs.vh
// register map, command bytes and timing figures of the flash command controller
`ifndef FCSM_REGS_VH
`define FCSM_REGS_VH

// ----------------------------------------------------------------------------
// apb register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define FCSM_REG_CTRL 8'h00
`define FCSM_REG_STATUS 8'h04
`define FCSM_REG_ADDR 8'h08
`define FCSM_REG_WDATA 8'h0C
`define FCSM_REG_RDATA 8'h10

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define FCSM_CTRL_OP_LSB 0
`define FCSM_CTRL_OP_MSB 2
`define FCSM_ST_BUSY 0
`define FCSM_ST_DONE 1
`define FCSM_ST_FAIL 2
`define FCSM_ST_REFUSED 3
`define FCSM_ST_BYPASS 4
`define FCSM_ST_AUTOSEL 5
`define FCSM_ADDR_RESET 17'h00000
`define FCSM_WDATA_RESET 8'h00

// ----------------------------------------------------------------------------
// operation codes written to the control register
// ----------------------------------------------------------------------------
`define FCSM_OP_RESET 3'h0
`define FCSM_OP_AUTOSEL 3'h1
`define FCSM_OP_PROGRAM 3'h2
`define FCSM_OP_BYP_ENTER 3'h3
`define FCSM_OP_BYP_PROGRAM 3'h4
`define FCSM_OP_BYP_EXIT 3'h5
`define FCSM_OP_CHIP_ERASE 3'h6
`define FCSM_OP_READ 3'h7

// ----------------------------------------------------------------------------
// device bus cycle addresses and data bytes
// ----------------------------------------------------------------------------
`define FCSM_UNLOCK_ADDR1 17'h00555
`define FCSM_UNLOCK_ADDR2 17'h002AA
`define FCSM_DONT_CARE_ADDR 17'h00000
`define FCSM_UNLOCK_DATA1 8'hAA
`define FCSM_UNLOCK_DATA2 8'h55
`define FCSM_CMD_RESET 8'hF0
`define FCSM_CMD_AUTOSEL 8'h90
`define FCSM_CMD_PROGRAM 8'hA0
`define FCSM_CMD_BYPASS 8'h20
`define FCSM_CMD_BYP_EXIT1 8'h90
`define FCSM_CMD_BYP_EXIT2 8'h00
`define FCSM_CMD_ERASE_SETUP 8'h80
`define FCSM_CMD_CHIP_ERASE 8'h10

// ----------------------------------------------------------------------------
// status bit positions on the byte data lines
// ----------------------------------------------------------------------------
`define FCSM_DQ_TOGGLE 6
`define FCSM_DQ_FAIL 5

// ----------------------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------------------
`define FCSM_CLK_MHZ 40
`define FCSM_T_WP_NS 35
`define FCSM_T_WPH_NS 30
`define FCSM_T_ACC_NS 100
`define FCSM_SYNC_STAGES 2

`endif

// ===== fcsm_sync.v
// two flip-flop synchroniser for the byte data lines
`timescale 1ns/1ps
`default_nettype none

module fcsm_sync #(
   parameter W = 8
) (
   // clock and reset
   input wire clk_in,
   input wire resetn_in,
   // asynchronous level in, synchronised level out
   input wire [W-1:0] d_in,
   output wire [W-1:0] q_out
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // first stage feeds only the second stage
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end

   assign q_out = sync_q;

endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the flash command controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_in = 0, resetn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, err;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0;
   wire [31:0] prdata_out;
   wire pready_out, pslverr_out, ce_n, we_n, oe_n, d_oe_n;
   wire [16:0] fa;
   wire [7:0] d_c, d_m;
   int n_fail = 0, n_checks = 0;
   always #12.5 clk_in = ~clk_in;
   fcsm_ctrl dut (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .flash_addr_out(fa), .flash_ce_n_out(ce_n), .flash_we_n_out(we_n), .flash_oe_n_out(oe_n),
      .byte_data_lines_in(d_oe_n ? d_m : d_c), .byte_data_lines_out(d_c),
      .byte_data_lines_oe_n_out(d_oe_n));
   fcsm_flash_mdl #(.MAKER(8'hC5), .DEV(8'h3A)) u_mdl (.addr_in(fa), .ce_n_in(ce_n),
      .we_n_in(we_n), .oe_n_in(oe_n), .data_in(d_c), .data_out(d_m));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic report_and_stop;
      if (n_fail == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do @(posedge clk_in); while (pready_out !== 1'b1);
      r = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   // load address and data, start, poll busy
   task automatic op(input logic [2:0] c, input logic [16:0] a, input logic [7:0] d,
                     output logic [31:0] st);
      apb(1'b1, 8'h08, {15'h0, a}, st);
      apb(1'b1, 8'h0C, {24'h0, d}, st);
      apb(1'b1, 8'h00, {29'h0, c}, st);
      apb(1'b0, 8'h04, 32'h0, st);
      while (st[0] !== 1'b0) apb(1'b0, 8'h04, 32'h0, st);
   endtask
   task automatic rd(input logic [16:0] a, input logic [7:0] e);
      logic [31:0] s;
      op(3'h7, a, 8'h00, s);
      apb(1'b0, 8'h10, 32'h0, s);
      chk(s, {24'h0, e});
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      logic [31:0] s;
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      apb(1'b0, 8'h04, 32'h0, s);
      chk(s, 32'h0);
      apb(1'b0, 8'h14, 32'h0, s);
      chk({31'h0, err}, 32'h1);
      op(3'h2, 17'h01234, 8'h3C, s);
      chk(s & 32'h3F, 32'h02);
      rd(17'h01234, 8'h3C);
      op(3'h2, 17'h01234, 8'hC3, s);
      rd(17'h01234, 8'h00);
      op(3'h1, 17'h0, 8'h00, s);
      chk(s & 32'h3F, 32'h22);
      rd(17'h1AB00, 8'hC5);
      rd(17'h00001, 8'h3A);
      rd(17'h04002, 8'h00);
      rd(17'h00001, 8'h3A);
      op(3'h0, 17'h1FFFF, 8'h00, s);
      chk(s & 32'h3F, 32'h02);
      rd(17'h01234, 8'h00);
      op(3'h4, 17'h00010, 8'h5A, s);
      chk(s & 32'h08, 32'h08);
      op(3'h3, 17'h0, 8'h00, s);
      chk(s & 32'h3F, 32'h12);
      op(3'h4, 17'h00010, 8'h5A, s);
      op(3'h4, 17'h00011, 8'hA5, s);
      op(3'h1, 17'h0, 8'h00, s);
      chk(s & 32'h18, 32'h18);
      op(3'h5, 17'h0, 8'h00, s);
      chk(s & 32'h3F, 32'h02);
      rd(17'h00010, 8'h5A);
      rd(17'h00011, 8'hA5);
      apb(1'b1, 8'h00, 32'h6, s);
      apb(1'b1, 8'h00, 32'h0, s);
      apb(1'b0, 8'h04, 32'h0, s);
      while (s[0] !== 1'b0) apb(1'b0, 8'h04, 32'h0, s);
      chk(s & 32'h37, 32'h02);
      chk(s & 32'h08, 32'h08);
      rd(17'h01234, 8'hFF);
      report_and_stop;
   end
   // a hung handshake or poll ends the run
   initial begin
      #(25 * 60000);
      n_fail++;
      report_and_stop;
   end
endmodule
`default_nettype wire
